// ==== design/adcsr_pkg.sv ====
// Purpose: Shared constants and types for the converter status/mode bank
// Assumes: Serial link sampled on mclk; MSB-first framing
// Notes: Register indices equal register_select codes
package adcsr_pkg;
  // Register select codes
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [2:0] SEL_CONFIG = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [23:0] MODE_RESET = 24'h080060;
  // Writable bits of the mode register (17,16,14,12 fixed zero)
  localparam logic [23:0] MODE_WMASK = 24'hfcafff;
  // Mode field positions
  localparam int MODE_APPEND_BIT = 20;
  localparam int MODE_PARITY_BIT = 13;
  // Status field positions
  localparam int SR_PEND = 7;
  localparam int SR_CLAMP = 6;
  localparam int SR_MISSING_REFERENCE_FLAG = 5;
  localparam int SR_PAR = 4;
  // Communications byte positions
  localparam int CR_GATE_N = 7;
  localparam int CR_READ = 6;
  localparam int CR_SEL_HI = 5;
  localparam int CR_SEL_LO = 3;
  // Frame lengths in bits
  localparam logic [5:0] LEN_CMD = 6'h08;
  localparam logic [5:0] LEN_STATUS = 6'h08;
  localparam logic [5:0] LEN_MODE = 6'h18;
  localparam logic [5:0] LEN_DATA = 6'h18;
  localparam logic [5:0] LEN_DATA_ST = 6'h20;

  // Converter-side events presented to the bank
  typedef struct packed {
    logic result_load;     // New result written to data register
    logic result_clamped;  // That result was clamped
    logic [2:0] channel;   // Channel used for that result
    logic [23:0] result;   // The result word
    logic pre_update;      // Warning: data about to be replaced
    logic power_idle;      // Entering power-down or idle
    logic ref_low;         // Selected reference below threshold
    logic conv_start;      // Write that starts a conversion
  } adcsr_conv_t;
endpackage : adcsr_pkg

// ==== design/adcsr_sync.sv ====
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Destination clock is mclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module adcsr_sync
#(
  parameter logic INIT = 1'b0 // Reset level, the idle level of the pin
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic meta; // First stage, read only by the second

  // Double register the pin
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      meta <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // adcsr_sync
`default_nettype wire

// ==== design/adcsr_bank.sv ====
// Purpose: Status and mode registers behind a three-wire serial port
// Assumes: Host changes serial_in on falling edge; device samples rising
// Notes: Output changes after falling edge; converter core is outside
`timescale 1ns/1ns
`default_nettype none
module adcsr_bank
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic filter_restart_n,
  input wire logic reference_detect_enable,
  input wire adcsr_pkg::adcsr_conv_t conv,
  output logic serial_out_ready_pin,
  output logic [23:0] operating_mode,
  output logic modulator_reset,
  output logic [7:0] converter_status
);
  // Serial state machine
  typedef enum logic [1:0]
  {
    ST_CMD = 2'b00,
    ST_WR = 2'b01,
    ST_RD = 2'b10
  } adcsr_state_t;

  adcsr_state_t state; // Current phase of access
  logic sclk_s; // Synchronised serial clock
  logic sdi_s; // Synchronised serial data
  logic restart_n_s; // Synchronised restart pin
  logic sclk_d; // Previous serial clock level
  logic rise; // Serial clock rising edge
  logic fall; // Serial clock falling edge
  logic [5:0] bit_cnt; // Bits handled in this phase
  logic [5:0] frame_len; // Length of data phase
  logic [6:0] cmd_sh; // Command bits after gate
  logic [23:0] wr_sh; // Incoming write bits
  logic [31:0] rd_sh; // Outgoing read bits
  logic [2:0] reg_sel; // Selected register
  logic [23:0] data_reg; // Held conversion result
  logic pend; // Conversion pending flag
  logic clamp; // Result clamped flag
  logic [2:0] chan_tag; // Source channel tag
  logic data_read_done; // Data register read finished
  logic mode_write; // Mode write completes
  logic cmd_done; // Last command bit sampled
  logic [23:0] wr_word; // Write word incl. last bit
  logic rd_bit; // Current outgoing bit
  logic [7:0] next_status; // Status value for the next cycle

  // Parity of the held result
  function automatic logic odd_ones(input logic [23:0] w);
    odd_ones = ^w;
  endfunction

  // Pin synchronisers; reset to idle high so no false edge follows reset
  adcsr_sync #(.INIT(1'b1)) u_sync_clk (.mclk(mclk), .reset(reset),
    .async_in(serial_clk), .sync_out(sclk_s));
  adcsr_sync #(.INIT(1'b1)) u_sync_din (.mclk(mclk), .reset(reset),
    .async_in(serial_in), .sync_out(sdi_s));
  adcsr_sync #(.INIT(1'b1)) u_sync_rst (.mclk(mclk), .reset(reset),
    .async_in(filter_restart_n), .sync_out(restart_n_s));

  // Edge detection on synchronised clock, idle high
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      sclk_d <= 1'b1;
    else
      sclk_d <= sclk_s;
  end
  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // Phase decode
  assign cmd_done = (state == ST_CMD) && rise && (bit_cnt != 6'h00)
    && (bit_cnt == adcsr_pkg::LEN_CMD - 6'h01);
  assign wr_word = {wr_sh[22:0], sdi_s};
  assign mode_write = (state == ST_WR) && rise
    && (bit_cnt == frame_len - 6'h01) && (reg_sel == adcsr_pkg::SEL_MODE);
  assign data_read_done = (state == ST_RD) && rise
    && (bit_cnt == frame_len - 6'h01) && (reg_sel == adcsr_pkg::SEL_DATA);

  // Data phase length per register
  always_comb
  begin
    unique case (reg_sel)
      adcsr_pkg::SEL_STATUS: frame_len = adcsr_pkg::LEN_STATUS;
      adcsr_pkg::SEL_DATA: frame_len =
        operating_mode[adcsr_pkg::MODE_APPEND_BIT] ? adcsr_pkg::LEN_DATA_ST
        : adcsr_pkg::LEN_DATA;
      default: frame_len = adcsr_pkg::LEN_MODE;
    endcase
  end

  // Command and phase sequencing
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_CMD;
      bit_cnt <= 6'h00;
      cmd_sh <= 7'h00;
      reg_sel <= 3'h0;
      wr_sh <= 24'h000000;
    end
    else
    begin
      unique case (state)
        ST_CMD:
        begin
          if (rise)
          begin
            if (bit_cnt == 6'h00)
            begin
              // Wait on a zero gate bit
              if (!sdi_s)
                bit_cnt <= 6'h01;
            end
            else if (cmd_done)
            begin
              bit_cnt <= 6'h00;
              reg_sel <= cmd_sh[4:2];
              if (cmd_sh[5])
                state <= ST_RD;
              else if (cmd_sh[4:2] == adcsr_pkg::SEL_MODE)
                state <= ST_WR;
              // Other writes are outside this bank
            end
            else
            begin
              cmd_sh <= {cmd_sh[5:0], sdi_s};
              bit_cnt <= bit_cnt + 6'h01;
            end
          end
        end
        ST_WR:
        begin
          if (rise)
          begin
            wr_sh <= wr_word;
            if (bit_cnt == frame_len - 6'h01)
            begin
              bit_cnt <= 6'h00;
              state <= ST_CMD;
            end
            else
              bit_cnt <= bit_cnt + 6'h01;
          end
        end
        ST_RD:
        begin
          // Leave on the last rising edge so the pin shows ready again
          if (rise)
          begin
            if (bit_cnt == frame_len - 6'h01)
            begin
              bit_cnt <= 6'h00;
              state <= ST_CMD;
            end
            else
              bit_cnt <= bit_cnt + 6'h01;
          end
        end
        default:
          state <= ST_CMD;
      endcase
    end
  end

  // Read shifter: loaded at command end, shifts on falling edges
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rd_sh <= 32'h00000000;
    else if (cmd_done)
    begin
      unique case (cmd_sh[4:2])
        adcsr_pkg::SEL_STATUS: rd_sh <= {converter_status, 24'h000000};
        adcsr_pkg::SEL_MODE: rd_sh <= {operating_mode, 8'h00};
        adcsr_pkg::SEL_DATA: rd_sh <= {data_reg, converter_status};
        default: rd_sh <= 32'h00000000;
      endcase
    end
    else if (state == ST_RD && fall && bit_cnt != 6'h00)
      rd_sh <= {rd_sh[30:0], 1'b0};
  end
  assign rd_bit = rd_sh[31];

  // Mode register; fixed-zero bits masked
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      operating_mode <= adcsr_pkg::MODE_RESET;
    else if (mode_write)
      operating_mode <= wr_word & adcsr_pkg::MODE_WMASK;
  end

  // Filter/modulator reset pulse on mode writes
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      modulator_reset <= 1'b0;
    else
      modulator_reset <= mode_write;
  end

  // Held result and its channel
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      data_reg <= 24'h000000;
      chan_tag <= 3'h0;
    end
    else if (conv.result_load)
    begin
      data_reg <= conv.result;
      chan_tag <= conv.channel;
    end
  end

  // Pending flag: set events win over load
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pend <= 1'b1;
    else if (data_read_done || conv.pre_update)
      pend <= 1'b1;
    else if (conv.power_idle || !restart_n_s)
      pend <= 1'b1;
    else if (mode_write)
      pend <= 1'b1;
    else if (conv.result_load)
      pend <= 1'b0;
  end

  // Clamped flag follows each result load
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      clamp <= 1'b0;
    else if (conv.result_load)
      clamp <= conv.result_clamped;
    else if (conv.conv_start || mode_write)
      clamp <= 1'b0;
  end

  // Status assembly from the live flags
  always_comb
  begin
    next_status = 8'h00;
    next_status[adcsr_pkg::SR_PEND] = pend;
    next_status[adcsr_pkg::SR_CLAMP] = clamp;
    next_status[adcsr_pkg::SR_MISSING_REFERENCE_FLAG] =
      conv.ref_low & reference_detect_enable;
    next_status[adcsr_pkg::SR_PAR] =
      operating_mode[adcsr_pkg::MODE_PARITY_BIT] & odd_ones(data_reg);
    next_status[2:0] = chan_tag;
  end

  // Status register, read-only to the host
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      converter_status <= adcsr_pkg::STATUS_RESET;
    else
      converter_status <= next_status;
  end

  // Shared out/ready pin: data while reading, else pending flag
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      serial_out_ready_pin <= 1'b1;
    else if (state == ST_RD)
      serial_out_ready_pin <= rd_bit;
    else
      serial_out_ready_pin <= pend;
  end

  // Checks, all on the core clock and idle while reset is high
  default clocking chk_clk @(posedge mclk);
  endclocking
  default disable iff (reset);
  chk_status_reset_val: assert property (
    $fell(reset) |-> converter_status == adcsr_pkg::STATUS_RESET
    && operating_mode == adcsr_pkg::MODE_RESET)
    else $error("register reset value wrong");
  chk_sr3_zero: assert property (
    converter_status[3] == 1'b0)
    else $error("status bit 3 not zero");
  chk_load_clears: assert property (
    conv.result_load && !conv.pre_update && !conv.power_idle
    && !data_read_done && !mode_write && restart_n_s |=> !pend)
    else $error("pending not cleared on load");
  chk_read_sets: assert property (
    data_read_done |=> pend)
    else $error("pending not set after data read");
  chk_mode_write_eff: assert property (
    mode_write |=> pend && modulator_reset ##1 !modulator_reset)
    else $error("mode write side effect missing");
  chk_mode_zeros: assert property (
    (operating_mode & ~adcsr_pkg::MODE_WMASK) == 24'h000000)
    else $error("fixed mode bits not zero");
  chk_missing_reference_flag_gate: assert property (
    !reference_detect_enable |=> !converter_status[adcsr_pkg::SR_MISSING_REFERENCE_FLAG])
    else $error("reference flag while disabled");
  chk_status_return: assert property (
    state == ST_RD && rise && bit_cnt == frame_len - 6'h01
    |=> state == ST_CMD)
    else $error("no return to command phase");
  chk_ready_pin: assert property (
    state == ST_CMD && $past(state) == ST_CMD |-> serial_out_ready_pin
    == $past(pend))
    else $error("ready pin not following pending");
endmodule // adcsr_bank
`default_nettype wire

// ==== sim/adcsr_host.sv ====
// Purpose: Host model driving the three-wire serial link
// Assumes: Link period 64 ns, clock idles high between frames
// Notes: Data line is inverted once released after a frame
`timescale 1ns/1ns
`default_nettype none
module adcsr_host
(
  input wire logic mclk,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out_ready_pin
);
  localparam int HALF = 8; // Core cycles per half link period
  // Idle state of the link
  initial
  begin
    serial_clk = 1'b1;
    serial_in = 1'b1;
  end
  // Half link period, counted on core falling edges
  task automatic half_wait();
    repeat (HALF) @(negedge mclk);
  endtask
  // One bit: drive on low phase, sample just before the rise
  task automatic bit_x(input logic b, output logic r);
    serial_clk = 1'b0;
    serial_in = b;
    half_wait();
    r = serial_out_ready_pin;
    serial_clk = 1'b1;
    half_wait();
  endtask
  // Leading ones that the device must skip
  task automatic ones(input int n);
    logic r;
    for (int i = 0; i < n; i++)
      bit_x(1'b1, r);
  endtask
  // Command byte then nbits of data, MSB first both ways
  task automatic xfer(input logic [7:0] cmd, input int nbits,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic r;
    rd = '0;
    for (int i = 7; i >= 0; i--)
      bit_x(cmd[i], r);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      bit_x(wd[i], r);
      rd = {rd[30:0], r};
    end
    // Released line must not keep the last value
    serial_in = ~serial_in;
    half_wait();
  endtask
endmodule // adcsr_host
`default_nettype wire

// ==== sim/test_adcsr_bank.sv ====
// Purpose: Self-checking bench for the status and mode bank
// Assumes: Host model drives the link; bench drives converter events
// Notes: Random values come from a fixed-seed xorshift
`timescale 1ns/1ns
`default_nettype none
module test_adcsr_bank;
  logic mclk = 1'b0; // Core clock
  logic reset = 1'b1; // Held at start
  logic filter_restart_n = 1'b1;
  logic reference_detect_enable = 1'b0;
  adcsr_pkg::adcsr_conv_t conv = '0; // Converter events
  wire logic serial_clk, serial_in, serial_out_ready_pin;
  wire logic modulator_reset;
  wire logic [23:0] operating_mode;
  wire logic [7:0] converter_status;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_mrst = 0; // Modulator reset pulses seen
  int nm;
  logic [31:0] seed = 32'h133c;
  logic [31:0] rd;
  logic [23:0] v, r;
  logic [2:0] ch;
  logic cl;
  logic pe = 1'b0; // Parity enable as last written, off after reset
  int k;
  always #2 mclk = ~mclk;
  adcsr_bank i_dut
  (
    .mclk(mclk),
    .reset(reset),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .filter_restart_n(filter_restart_n),
    .reference_detect_enable(reference_detect_enable),
    .conv(conv),
    .serial_out_ready_pin(serial_out_ready_pin),
    .operating_mode(operating_mode),
    .modulator_reset(modulator_reset),
    .converter_status(converter_status)
  );
  adcsr_host u_host
  (
    .mclk(mclk),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .serial_out_ready_pin(serial_out_ready_pin)
  );
  // Count modulator reset pulses
  always @(posedge mclk)
    if (modulator_reset === 1'b1)
      n_mrst++;
  // Fixed-seed xorshift
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Mode readback: bits 17, 16, 14, 12 stay zero
  function automatic logic [23:0] exp_mode(input logic [23:0] w);
    return w & ~24'h035000;
  endfunction
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // New result into the data register
  task automatic load(input logic [23:0] d, input logic [2:0] c,
                      input logic e);
    @(negedge mclk);
    conv.result = d;
    conv.channel = c;
    conv.result_clamped = e;
    conv.result_load = 1'b1;
    @(negedge mclk);
    conv.result_load = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  // One-cycle event of the given kind
  task automatic fire(input int kind);
    @(negedge mclk);
    case (kind)
      0: conv.pre_update = 1'b1;
      1: conv.power_idle = 1'b1;
      2: filter_restart_n = 1'b0;
      default: conv.conv_start = 1'b1;
    endcase
    @(negedge mclk);
    conv.pre_update = 1'b0;
    conv.power_idle = 1'b0;
    conv.conv_start = 1'b0;
    filter_restart_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    check(converter_status, 8'h80, "status reset");
    check(operating_mode, 24'h080060, "mode reset");
    check(serial_out_ready_pin, 1'b1, "pin idle");
    u_host.ones(5);
    u_host.xfer(8'h40, 8, 0, rd);
    check(rd, 32'h80, "status shift");
    u_host.xfer(8'h48, 24, 0, rd);
    check(rd, 32'h080060, "mode shift");
    // Refused write, then a status read must still work
    u_host.xfer(8'h10, 0, 0, rd);
    u_host.xfer(8'h40, 8, 0, rd);
    check(rd, 32'h80, "after refused");
    for (int i = 0; i < 8; i++)
    begin
      k = i % 4;
      ch = 3'(rnd());
      cl = rnd() & 1;
      r = 24'(rnd());
      load(r, ch, cl);
      check(converter_status, {1'b0, cl, 1'b0, pe & ^r, 1'b0, ch},
            "load");
      check(serial_out_ready_pin, 1'b0, "pin ready");
      fire(k);
      check(converter_status[7:6], {k != 3, cl & (k != 3)},
            "event");
      v = (i == 0) ? 24'hffffff : 24'(rnd());
      v[20] = i[0]; // Append status when parity is on
      v[13] = i[0];
      nm = n_mrst;
      u_host.xfer(8'h08, 24, {8'h00, v}, rd);
      pe = v[13];
      check(operating_mode, exp_mode(v), "mode port");
      check(n_mrst - nm, 1, "mod reset");
      check(converter_status[7], 1'b1, "write pend");
      u_host.xfer(8'h48, 24, 0, rd);
      check(rd[23:0], exp_mode(v), "mode read");
      r = 24'(rnd());
      ch = 3'(rnd());
      cl = rnd() & 1;
      load(r, ch, cl);
      check(converter_status[6], cl, "clamp");
      if (v[13])
        check(converter_status[4], ^r, "parity");
      u_host.xfer(8'h58, v[20] ? 32 : 24, 0, rd);
      if (v[20])
        check({rd[31:8], rd[4:0]}, {r, ^r, 1'b0, ch}, "data+st");
      else
        check(rd[23:0], r, "data");
      check(converter_status[7], 1'b1, "read pend");
      // Two status reads back to back
      u_host.xfer(8'h40, 8, 0, rd);
      u_host.xfer(8'h40, 8, 0, rd);
      check({rd[7:5], rd[3:0]}, {1'b1, cl, 5'(ch)}, "st read");
    end
    // Reference flag over all enable and level pairs
    for (int j = 0; j < 4; j++)
    begin
      @(negedge mclk);
      reference_detect_enable = j[1];
      conv.ref_low = j[0];
      repeat (4) @(negedge mclk);
      check(converter_status[5], j == 3, "missing_reference_flag");
    end
    summarize();
  end
  // Watchdog
  initial
  begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule // test_adcsr_bank
`default_nettype wire
